/* rtl/sirp_core.v */
// Serial interface core: flags, interrupts, transmit queue, resets and pins
`timescale 1ns/10ps
`default_nettype none
`include "sirp_map.vh"

module sirp_core #(
  parameter DATA_W = 8
) (
  input wire mclk,
  input wire rst,
  // CPU side
  input wire waitMode,
  input wire stopMode,
  input wire breakActive,
  input wire breakClearEnable,
  input wire serialControlWr,
  input wire wrTxIrqEnable,
  input wire wrRxIrqEnable,
  input wire wrMasterSelect,
  input wire wrCpol,
  input wire wrCpha,
  input wire wrWiredOrMode,
  input wire wrModuleEnable,
  input wire statusControlWr,
  input wire wrErrorIrqEnable,
  input wire wrModeFaultEnable,
  input wire wrRateSelectHi,
  input wire wrRateSelectLo,
  input wire statusRd,
  input wire dataRd,
  input wire dataWr,
  input wire [DATA_W-1:0] dataWrByte,
  output wire [DATA_W-1:0] rxData,
  output reg txIrqEnable_ff,
  output reg rxIrqEnable_ff,
  output reg masterSelect_ff,
  output reg cpol_ff,
  output reg cpha_ff,
  output reg wiredOrMode_ff,
  output reg moduleEnable_ff,
  output reg errorIrqEnable_ff,
  output reg modeFaultEnable_ff,
  output reg rateSelectHi_ff,
  output reg rateSelectLo_ff,
  output reg txEmptyFlag_ff,
  output reg rxFullFlag_ff,
  output reg overflowFlag_ff,
  output reg modeFaultFlag_ff,
  output wire txIrq,
  output wire rxErrIrq,
  output wire wakeReq,
  // Pins
  output wire pinsOwned,
  input wire serialClockIn,
  output wire serialClockOut,
  output wire serialClockOe,
  input wire mosiIn,
  output wire mosiOut,
  output wire mosiOe,
  input wire misoIn,
  output wire misoOut,
  output wire misoOe,
  input wire slaveSelectIn_n
);

  localparam EW = $clog2(2 * DATA_W);
  localparam LAST_EDGE = 2 * DATA_W - 1;

  reg [DATA_W-1:0] txBuf_ff;
  reg [DATA_W-1:0] shift_ff;
  reg [DATA_W-1:0] rxData_ff;
  reg [EW-1:0] edgeCnt_ff;
  reg busy_ff;
  reg halfWait_ff;
  reg lostByte_ff;
  reg sckAct_ff;
  reg outBit_ff;
  reg captBit_ff;
  reg sckPrev_ff;
  reg ssPrev_ff;
  reg modfArm_ff;
  reg ovrArm_ff;

  wire [3:0] pinSync;
  wire sckS;
  wire mosiS;
  wire misoS;
  wire ssS_n;
  wire tick;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers and master clock divider

  sirp_sync #(
    .WIDTH(4),
    .RST_VAL(4'h8)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .asyncIn({slaveSelectIn_n, serialClockIn, mosiIn, misoIn}),
    .syncOut(pinSync)
  );

  assign ssS_n = pinSync[3];
  assign sckS = pinSync[2];
  assign mosiS = pinSync[1];
  assign misoS = pinSync[0];

  wire active = moduleEnable_ff & ~stopMode;

  sirp_baud #(
    .CNT_W(7)
  ) u_baud (
    .mclk(mclk),
    .rst(rst),
    .enable(active & masterSelect_ff),
    .rateSel({rateSelectHi_ff, rateSelectLo_ff}),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access qualifiers

  wire cpuOk = ~waitMode;
  wire blockClr = breakActive & ~breakClearEnable;
  wire dataWrOk = dataWr & cpuOk & ~blockClr & moduleEnable_ff;
  wire dataRdOk = dataRd & cpuOk;
  wire statusRdOk = statusRd & cpuOk & ~blockClr;
  wire ctrlWrOk = serialControlWr & cpuOk;
  wire statCtrlWrOk = statusControlWr & cpuOk;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock edges

  wire isMaster = masterSelect_ff;
  wire slaveSel = active & ~isMaster & ~ssS_n;
  wire slaveStart = slaveSel & ssPrev_ff & ~cpha_ff & ~busy_ff;
  wire slaveAbort = active & ~isMaster & ssS_n & busy_ff;
  wire sckToggle = sckS ^ sckPrev_ff;
  wire slaveEdge = slaveSel & sckToggle & (busy_ff | cpha_ff);
  wire masterEdge = active & isMaster & busy_ff & tick & ~halfWait_ff;
  wire edgeAny = masterEdge | slaveEdge;
  wire edgeLead = isMaster ? ~sckAct_ff : (sckS ^ cpol_ff);
  wire sampleEdge = edgeAny & (edgeLead ^ cpha_ff);
  wire shiftEdge = edgeAny & ~(edgeLead ^ cpha_ff);
  wire lastEdge = edgeAny & (edgeCnt_ff == LAST_EDGE[EW-1:0]);
  wire firstSample = sampleEdge & (edgeCnt_ff[EW-1:1] == {(EW-1){1'b0}});
  wire inBit = isMaster ? misoS : mosiS;
  wire [DATA_W-1:0] newByte = {shift_ff[DATA_W-2:0], cpha_ff ? inBit : captBit_ff};

  // Buffer moves to shifter when idle or at the end of a byte
  wire loadNow = active & ~txEmptyFlag_ff & ((~busy_ff & ~edgeAny) | lastEdge);
  wire masterFault = active & isMaster & modeFaultEnable_ff & ~ssS_n;
  wire slaveFault = slaveAbort & modeFaultEnable_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Control bits, loaded by writes and by system reset; a master mode fault also clears moduleEnable_ff

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      txIrqEnable_ff <= `SIRP_RST_TX_IRQ_EN;
      rxIrqEnable_ff <= `SIRP_RST_RX_IRQ_EN;
      masterSelect_ff <= `SIRP_RST_MASTER;
      cpol_ff <= `SIRP_RST_CPOL;
      cpha_ff <= `SIRP_RST_CPHA;
      wiredOrMode_ff <= `SIRP_RST_WIRED_OR;
      moduleEnable_ff <= `SIRP_RST_ENABLE;
      errorIrqEnable_ff <= `SIRP_RST_ERR_IRQ_EN;
      modeFaultEnable_ff <= `SIRP_RST_MODE_FAULT_FLAG_EN;
      {rateSelectHi_ff, rateSelectLo_ff} <= `SIRP_RST_RATE;
    end else begin
      if (ctrlWrOk) begin
        txIrqEnable_ff <= wrTxIrqEnable;
        rxIrqEnable_ff <= wrRxIrqEnable;
        masterSelect_ff <= wrMasterSelect;
        cpol_ff <= wrCpol;
        cpha_ff <= wrCpha;
        wiredOrMode_ff <= wrWiredOrMode;
        moduleEnable_ff <= wrModuleEnable;
      end
      if (masterFault) begin
        moduleEnable_ff <= 1'b0;
      end
      if (statCtrlWrOk) begin
        errorIrqEnable_ff <= wrErrorIrqEnable;
        modeFaultEnable_ff <= wrModeFaultEnable;
        rateSelectHi_ff <= wrRateSelectHi;
        rateSelectLo_ff <= wrRateSelectLo;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set wins over a clear in the same cycle

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      txEmptyFlag_ff <= `SIRP_RST_TX_EMPTY;
      rxFullFlag_ff <= `SIRP_RST_RX_FULL;
      overflowFlag_ff <= `SIRP_RST_OVERFLOW;
      modeFaultFlag_ff <= `SIRP_RST_MODE_FAULT;
      modfArm_ff <= 1'b0;
      ovrArm_ff <= 1'b0;
    end else begin
      if (~moduleEnable_ff | loadNow) begin
        txEmptyFlag_ff <= 1'b1;
      end else if (dataWrOk) begin
        txEmptyFlag_ff <= 1'b0;
      end
      if (lastEdge & ~lostByte_ff) begin
        rxFullFlag_ff <= 1'b1;
      end else if (dataRdOk & ~blockClr) begin
        rxFullFlag_ff <= 1'b0;
      end
      if (firstSample & rxFullFlag_ff) begin
        overflowFlag_ff <= 1'b1;
        ovrArm_ff <= 1'b0;
      end else if (dataRdOk & ~blockClr & ovrArm_ff) begin
        overflowFlag_ff <= 1'b0;
        ovrArm_ff <= 1'b0;
      end else if (statusRdOk & overflowFlag_ff) begin
        ovrArm_ff <= 1'b1;
      end
      if (masterFault | slaveFault) begin
        modeFaultFlag_ff <= 1'b1;
        modfArm_ff <= 1'b0;
      end else if (ctrlWrOk & ~blockClr & modfArm_ff) begin
        modeFaultFlag_ff <= 1'b0;
        modfArm_ff <= 1'b0;
      end else if (statusRdOk & modeFaultFlag_ff) begin
        modfArm_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer, shifter and transfer state

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      txBuf_ff <= {DATA_W{1'b0}};
      shift_ff <= {DATA_W{1'b0}};
      rxData_ff <= {DATA_W{1'b0}};
      edgeCnt_ff <= {EW{1'b0}};
      busy_ff <= 1'b0;
      halfWait_ff <= 1'b0;
      lostByte_ff <= 1'b0;
      sckAct_ff <= 1'b0;
      outBit_ff <= 1'b0;
      captBit_ff <= 1'b0;
      sckPrev_ff <= 1'b0;
      ssPrev_ff <= 1'b1;
    end else begin
      sckPrev_ff <= sckS;
      ssPrev_ff <= ssS_n;
      if (dataWrOk) begin
        txBuf_ff <= dataWrByte;
      end
      if (~moduleEnable_ff) begin
        busy_ff <= 1'b0;
        shift_ff <= {DATA_W{1'b0}};
        edgeCnt_ff <= {EW{1'b0}};
        halfWait_ff <= 1'b0;
        lostByte_ff <= 1'b0;
        sckAct_ff <= 1'b0;
      end else if (slaveAbort) begin
        busy_ff <= 1'b0;
        edgeCnt_ff <= {EW{1'b0}};
        lostByte_ff <= 1'b0;
      end else begin
        if (masterEdge) begin
          sckAct_ff <= ~sckAct_ff;
        end
        if (active & isMaster & busy_ff & tick & halfWait_ff) begin
          halfWait_ff <= 1'b0;
        end
        if (slaveStart) begin
          busy_ff <= 1'b1;
          edgeCnt_ff <= {EW{1'b0}};
        end
        if (edgeAny) begin
          busy_ff <= 1'b1;
          edgeCnt_ff <= edgeCnt_ff + {{(EW-1){1'b0}}, 1'b1};
        end
        if (sampleEdge) begin
          captBit_ff <= inBit;
        end
        if (firstSample & rxFullFlag_ff) begin
          lostByte_ff <= 1'b1;
        end
        if (edgeAny & edgeLead & cpha_ff) begin
          outBit_ff <= shift_ff[DATA_W-1];
        end
        if (shiftEdge & ~cpha_ff & ~lastEdge) begin
          shift_ff <= newByte;
        end
        if (sampleEdge & cpha_ff & ~lastEdge) begin
          shift_ff <= newByte;
        end
        if (lastEdge) begin
          edgeCnt_ff <= {EW{1'b0}};
          lostByte_ff <= 1'b0;
          busy_ff <= isMaster & loadNow;
          shift_ff <= loadNow ? txBuf_ff : newByte;
          if (~lostByte_ff) begin
            rxData_ff <= newByte;
          end
        end else if (loadNow) begin
          shift_ff <= txBuf_ff;
          busy_ff <= isMaster;
        end
        if (loadNow & isMaster) begin
          halfWait_ff <= ~cpha_ff;
        end
      end
    end
  end

  assign rxData = rxData_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request levels

  assign txIrq = txEmptyFlag_ff & txIrqEnable_ff;
  assign rxErrIrq = (rxFullFlag_ff & rxIrqEnable_ff & moduleEnable_ff)
    | (errorIrqEnable_ff & (overflowFlag_ff | modeFaultFlag_ff));
  assign wakeReq = waitMode & (txIrq | rxErrIrq);

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers: {oe, out}; wired-OR drives low only

  function [1:0] padDrive;
    input en;
    input level;
    input wom;
    begin
      if (~en) begin
        padDrive = 2'h0;
      end else if (wom) begin
        padDrive = {~level, 1'b0};
      end else begin
        padDrive = {1'b1, level};
      end
    end
  endfunction

  wire dataBit = cpha_ff ? outBit_ff : shift_ff[DATA_W-1];
  wire [1:0] sckPad = padDrive(moduleEnable_ff & isMaster, cpol_ff ^ sckAct_ff,
    wiredOrMode_ff);
  wire [1:0] mosiPad = padDrive(moduleEnable_ff & isMaster, dataBit,
    wiredOrMode_ff);
  wire [1:0] misoPad = padDrive(moduleEnable_ff & ~isMaster & ~ssS_n, dataBit,
    wiredOrMode_ff);

  assign pinsOwned = moduleEnable_ff;
  assign serialClockOe = sckPad[1];
  assign serialClockOut = sckPad[0];
  assign mosiOe = mosiPad[1];
  assign mosiOut = mosiPad[0];
  assign misoOe = misoPad[1];
  assign misoOut = misoPad[0];

endmodule

`default_nettype wire

/* rtl/sirp_map.vh */
// Constants for the serial interface interrupt, reset and pin logic
`ifndef SIRP_MAP_VH
`define SIRP_MAP_VH

// Control bit reset values
`define SIRP_RST_TX_IRQ_EN 1'h0
`define SIRP_RST_RX_IRQ_EN 1'h0
`define SIRP_RST_MASTER 1'h1
`define SIRP_RST_CPOL 1'h0
`define SIRP_RST_CPHA 1'h1
`define SIRP_RST_WIRED_OR 1'h0
`define SIRP_RST_ENABLE 1'h0
`define SIRP_RST_ERR_IRQ_EN 1'h0
`define SIRP_RST_MODE_FAULT_FLAG_EN 1'h0
`define SIRP_RST_RATE 2'h0

// Status flag reset values
`define SIRP_RST_TX_EMPTY 1'h1
`define SIRP_RST_RX_FULL 1'h0
`define SIRP_RST_OVERFLOW 1'h0
`define SIRP_RST_MODE_FAULT 1'h0

// Rate select codes
`define SIRP_RATE_DIV2 2'h0
`define SIRP_RATE_DIV8 2'h1
`define SIRP_RATE_DIV32 2'h2
`define SIRP_RATE_DIV128 2'h3

// Half serial clock period in bus clock cycles per rate
`define SIRP_HALF_DIV2 7'h01
`define SIRP_HALF_DIV8 7'h04
`define SIRP_HALF_DIV32 7'h10
`define SIRP_HALF_DIV128 7'h40

// Synchroniser depth
`define SIRP_SYNC_STAGES 2

`endif

/* rtl/sirp_sync.v */
// Two flip-flop synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none

module sirp_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] meta_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end

endmodule

`default_nettype wire

/* rtl/sirp_baud.v */
// Master serial clock half-period tick generator
`timescale 1ns/10ps
`default_nettype none
`include "sirp_map.vh"

module sirp_baud #(
  parameter CNT_W = 7
) (
  input wire mclk,
  input wire rst,
  input wire enable,
  input wire [1:0] rateSel,
  output wire tick
);

  reg [CNT_W-1:0] cnt_ff;
  wire [CNT_W-1:0] halfLen;

  function [CNT_W-1:0] halfOf;
    input [1:0] sel;
    begin
      case (sel)
        `SIRP_RATE_DIV2: halfOf = `SIRP_HALF_DIV2;
        `SIRP_RATE_DIV8: halfOf = `SIRP_HALF_DIV8;
        `SIRP_RATE_DIV32: halfOf = `SIRP_HALF_DIV32;
        default: halfOf = `SIRP_HALF_DIV128;
      endcase
    end
  endfunction

  assign halfLen = halfOf(rateSel);
  assign tick = enable & (cnt_ff == halfLen - {{(CNT_W-1){1'b0}}, 1'b1});

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= {CNT_W{1'b0}};
    end else if (~enable | tick) begin
      cnt_ff <= {CNT_W{1'b0}};
    end else begin
      cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

/* dv/sirp_core_props.sv */
// Port-level property checker for the serial interface core
`timescale 1ns/10ps
`default_nettype none
module sirp_core_props (
  input wire mclk,
  input wire rst,
  input wire waitMode,
  input wire txIrqEnable_ff,
  input wire rxIrqEnable_ff,
  input wire masterSelect_ff,
  input wire wiredOrMode_ff,
  input wire moduleEnable_ff,
  input wire errorIrqEnable_ff,
  input wire modeFaultEnable_ff,
  input wire txEmptyFlag_ff,
  input wire rxFullFlag_ff,
  input wire overflowFlag_ff,
  input wire modeFaultFlag_ff,
  input wire txIrq,
  input wire rxErrIrq,
  input wire wakeReq,
  input wire pinsOwned,
  input wire serialClockOe,
  input wire mosiOut,
  input wire mosiOe,
  input wire misoOe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  tx_req_a: assert property (txIrq == (txEmptyFlag_ff && txIrqEnable_ff))
    else $error("transmit request wrong");
  rx_req_a: assert property (rxErrIrq == ((rxFullFlag_ff && rxIrqEnable_ff && moduleEnable_ff)
    || (errorIrqEnable_ff && (overflowFlag_ff || modeFaultFlag_ff))))
    else $error("receive request wrong");
  wake_req_a: assert property (wakeReq == (waitMode && (txIrq || rxErrIrq)))
    else $error("wake request wrong");
  fault_gate_a: assert property (!modeFaultEnable_ff && !modeFaultFlag_ff |=> !modeFaultFlag_ff)
    else $error("mode fault set while detection off");
  idle_empty_a: assert property (!moduleEnable_ff ##1 !moduleEnable_ff |-> txEmptyFlag_ff)
    else $error("empty flag not set while disabled");
  pins_free_a: assert property (!moduleEnable_ff |-> !(pinsOwned || serialClockOe || mosiOe
    || misoOe))
    else $error("pins held while disabled");
  miso_slave_a: assert property (misoOe |-> moduleEnable_ff && !masterSelect_ff)
    else $error("data out driven outside slave mode");
  open_drain_a: assert property (wiredOrMode_ff && mosiOe |-> !mosiOut)
    else $error("wired mode drives high");
endmodule
bind sirp_core sirp_core_props i_props (.mclk, .rst, .waitMode, .txIrqEnable_ff, .rxIrqEnable_ff,
  .masterSelect_ff, .wiredOrMode_ff, .moduleEnable_ff, .errorIrqEnable_ff, .modeFaultEnable_ff,
  .txEmptyFlag_ff, .rxFullFlag_ff, .overflowFlag_ff, .modeFaultFlag_ff, .txIrq, .rxErrIrq,
  .wakeReq, .pinsOwned, .serialClockOe, .mosiOut, .mosiOe, .misoOe);
`default_nettype wire

/* dv/sirp_peer.sv */
// Far-end slave peer, phase-one format, answering each byte
`timescale 1ns/10ps
`default_nettype none
module sirp_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  input wire logic [7:0] txByte,
  output var logic misoOut,
  output logic misoEn,
  output var logic [7:0] rxByte,
  output var int bits
);
  logic [7:0] txSh;
  initial begin
    bits = 0;
    misoOut = 1'b0;
    rxByte = 8'h00;
    txSh = 8'h00;
  end
  // Released line falls to the pull-up
  assign misoEn = !selN;
  always @(posedge sck) begin
    if (!selN) begin
      misoOut <= (bits % 8 == 0) ? txByte[7] : txSh[7];
      txSh <= (bits % 8 == 0) ? {txByte[6:0], 1'b0} : {txSh[6:0], 1'b0};
    end
  end
  always @(negedge sck) begin
    if (!selN) begin
      rxByte <= {rxByte[6:0], mosi};
      bits <= bits + 1;
    end
  end
endmodule
`default_nettype wire

/* dv/tb_spi_interrupt_reset_pin_logic.sv */
// Self-checking bench for the serial interrupt, reset and pin logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
`define WAIT(c) for (int w = 0; w < 300 && ((c) !== 1'b1); w++) @(posedge mclk)
module tb_spi_interrupt_reset_pin_logic;
  localparam logic [4:0] CW = 5'h10, SW = 5'h08, SR = 5'h04, DR = 5'h02, DW = 5'h01;
  logic mclk, rst, waitMode, stopMode, breakActive, breakClearEnable, slaveSelectIn_n;
  logic serialControlWr, statusControlWr, statusRd, dataRd, dataWr, peerSel_n;
  logic wrTxIrqEnable, wrRxIrqEnable, wrMasterSelect, wrCpol, wrCpha, wrWiredOrMode;
  logic wrModuleEnable, wrErrorIrqEnable, wrModeFaultEnable, wrRateSelectHi, wrRateSelectLo;
  logic [4:0] stb;
  logic [6:0] scw;
  logic [3:0] ssw;
  logic [7:0] dataWrByte, rxData, peerTx, peerRx;
  logic txIrqEnable_ff, rxIrqEnable_ff, masterSelect_ff, cpol_ff, cpha_ff, wiredOrMode_ff;
  logic moduleEnable_ff, errorIrqEnable_ff, modeFaultEnable_ff, rateSelectHi_ff;
  logic rateSelectLo_ff, txEmptyFlag_ff, rxFullFlag_ff, overflowFlag_ff, modeFaultFlag_ff;
  logic txIrq, rxErrIrq, wakeReq, pinsOwned, serialClockOut, serialClockOe, mosiOut, mosiOe;
  logic misoOut, misoOe, peerMiso, peerMisoEn, sck, mosi, miso;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  int peerBits;
  wire [10:0] ctrlBits = {txIrqEnable_ff, rxIrqEnable_ff, masterSelect_ff, cpol_ff, cpha_ff,
    wiredOrMode_ff, moduleEnable_ff, errorIrqEnable_ff, modeFaultEnable_ff, rateSelectHi_ff,
    rateSelectLo_ff};
  wire [3:0] flags = {txEmptyFlag_ff, rxFullFlag_ff, overflowFlag_ff, modeFaultFlag_ff};
  wire [3:0] oes = {pinsOwned, serialClockOe, mosiOe, misoOe};
  assign {serialControlWr, statusControlWr, statusRd, dataRd, dataWr} = stb;
  assign {wrTxIrqEnable, wrRxIrqEnable, wrMasterSelect, wrCpol, wrCpha, wrWiredOrMode,
    wrModuleEnable} = scw;
  assign {wrErrorIrqEnable, wrModeFaultEnable, wrRateSelectHi, wrRateSelectLo} = ssw;
  // Pull-ups on every serial wire
  assign sck = serialClockOe ? serialClockOut : 1'b1;
  assign mosi = mosiOe ? mosiOut : 1'b1;
  assign miso = misoOe ? misoOut : (peerMisoEn ? peerMiso : 1'b1);
  sirp_core #(.DATA_W(8)) i_dut (.mclk, .rst, .waitMode, .stopMode, .breakActive,
    .breakClearEnable, .serialControlWr, .wrTxIrqEnable, .wrRxIrqEnable, .wrMasterSelect,
    .wrCpol, .wrCpha, .wrWiredOrMode, .wrModuleEnable, .statusControlWr, .wrErrorIrqEnable,
    .wrModeFaultEnable, .wrRateSelectHi, .wrRateSelectLo, .statusRd, .dataRd, .dataWr,
    .dataWrByte, .rxData, .txIrqEnable_ff, .rxIrqEnable_ff, .masterSelect_ff, .cpol_ff,
    .cpha_ff, .wiredOrMode_ff, .moduleEnable_ff, .errorIrqEnable_ff, .modeFaultEnable_ff,
    .rateSelectHi_ff, .rateSelectLo_ff, .txEmptyFlag_ff, .rxFullFlag_ff, .overflowFlag_ff,
    .modeFaultFlag_ff, .txIrq, .rxErrIrq, .wakeReq, .pinsOwned, .serialClockIn(sck),
    .serialClockOut, .serialClockOe, .mosiIn(mosi), .mosiOut, .mosiOe, .misoIn(miso),
    .misoOut, .misoOe, .slaveSelectIn_n);
  sirp_peer i_peer (.sck, .mosi, .selN(peerSel_n), .txByte(peerTx), .misoOut(peerMiso),
    .misoEn(peerMisoEn), .rxByte(peerRx), .bits(peerBits));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  task strobe(input logic [4:0] s, input logic [7:0] v);
    @(posedge mclk);
    stb <= s;
    scw <= v[6:0];
    ssw <= v[3:0];
    dataWrByte <= v;
    @(posedge mclk);
    stb <= 5'h00;
    #1;
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task testReset();
    @(posedge mclk);
    rst <= 1'b1;
    step(4);
    rst <= 1'b0;
    `CHK("controls", 11'h140, ctrlBits)
    `CHK("flags", 4'h8, flags)
    `CHK("pins", 4'h0, oes)
    `CHK("rxData", 8'h00, rxData)
  endtask
  task testMaster();
    strobe(SW, 8'h09);
    strobe(CW, 8'h75);
    peerSel_n = 1'b0;
    peerTx = 8'h3c;
    `CHK("pins", 4'he, oes)
    `CHK("sckOut", 1'b0, serialClockOut)
    `CHK("txIrq", 1'b1, txIrq)
    strobe(DW, 8'ha5);
    `CHK("txIrq", 1'b0, txIrq)
    `WAIT(rxFullFlag_ff);
    #1;
    `CHK("rxData", 8'h3c, rxData)
    `CHK("peerRx", 8'ha5, peerRx)
    `CHK("peerBits", 8, peerBits)
    `CHK("rxIrq", 1'b1, rxErrIrq)
    `CHK("txEmpty", 1'b1, txEmptyFlag_ff)
    strobe(DR, 8'h00);
    `CHK("rxFull", 1'b0, rxFullFlag_ff)
    `CHK("rxIrq", 1'b0, rxErrIrq)
  endtask
  task testQueue();
    peerTx = 8'h5a;
    strobe(DW, 8'h81);
    step(1);
    `CHK("txEmpty", 1'b1, txEmptyFlag_ff)
    strobe(DW, 8'h42);
    `WAIT(rxFullFlag_ff);
    // Lost byte differs from the kept one
    peerTx = 8'hc3;
    `WAIT(overflowFlag_ff);
    #1;
    `CHK("overflow", 1'b1, overflowFlag_ff)
    `CHK("rxData", 8'h5a, rxData)
    for (int i = 0; i < 300 && peerBits < 24; i++) @(posedge mclk);
    #1;
    `CHK("peerRx", 8'h42, peerRx)
  endtask
  task testBreak();
    @(posedge mclk);
    breakActive <= 1'b1;
    strobe(SR, 8'h00);
    strobe(DR, 8'h00);
    `CHK("flags", 4'he, flags)
    strobe(DW, 8'hff);
    step(40);
    `CHK("peerBits", 24, peerBits)
    `CHK("txEmpty", 1'b1, txEmptyFlag_ff)
    breakClearEnable <= 1'b1;
    strobe(DR, 8'h00);
    breakActive <= 1'b0;
    breakClearEnable <= 1'b0;
    step(2);
    `CHK("flags", 4'ha, flags)
    `CHK("rxIrq", 1'b1, rxErrIrq)
  endtask
  task testStop();
    int bitsHeld;
    peerTx = 8'h96;
    strobe(DW, 8'hc3);
    step(20);
    stopMode <= 1'b1;
    bitsHeld = peerBits;
    step(100);
    `CHK("stopBits", bitsHeld, peerBits)
    `CHK("stopEnable", 1'b1, moduleEnable_ff)
    stopMode <= 1'b0;
    `WAIT(rxFullFlag_ff);
    #1;
    `CHK("peerRx", 8'hc3, peerRx)
    `CHK("rxData", 8'h96, rxData)
    strobe(DR, 8'h00);
  endtask
  task testDisable();
    peerSel_n = 1'b1;
    strobe(DW, 8'h99);
    step(2);
    strobe(DW, 8'h66);
    `CHK("txEmpty", 1'b0, txEmptyFlag_ff)
    strobe(CW, 8'h74);
    step(1);
    `CHK("flags", 4'ha, flags)
    `CHK("pins", 4'h0, oes)
    `CHK("controls", 11'h749, ctrlBits)
  endtask
  task testWait();
    waitMode <= 1'b1;
    strobe(CW, 8'h00);
    `CHK("wake", 1'b1, wakeReq)
    `CHK("controls", 11'h749, ctrlBits)
    waitMode <= 1'b0;
  endtask
  task testFault();
    strobe(CW, 8'h77);
    slaveSelectIn_n <= 1'b0;
    step(6);
    `CHK("mode_fault_flag", 1'b0, modeFaultFlag_ff)
    `CHK("mosiOut", 1'b0, mosiOut)
    `CHK("sckOe", 1'b1, serialClockOe)
    strobe(SW, 8'h0d);
    step(2);
    `CHK("enable", 1'b0, moduleEnable_ff)
    `CHK("mode_fault_flag", 1'b1, modeFaultFlag_ff)
    slaveSelectIn_n <= 1'b1;
  endtask
  task testSlave();
    strobe(CW, 8'h21);
    `CHK("pins", 4'h8, oes)
    strobe(DW, 8'h80);
    step(1);
    slaveSelectIn_n <= 1'b0;
    step(4);
    `CHK("misoOe", 1'b1, misoOe)
    `CHK("misoOut", 1'b1, misoOut)
    slaveSelectIn_n <= 1'b1;
    step(4);
    `CHK("misoOe", 1'b0, misoOe)
  endtask
  task results();
    $display("Counts: %0d checks, %0d mismatches", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {waitMode, stopMode, breakActive, breakClearEnable, slaveSelectIn_n} = 5'h01;
    {stb, scw, ssw, dataWrByte} = '0;
    peerSel_n = 1'b1;
    peerTx = 8'h00;
    testReset();
    $display("reset test done");
    testMaster();
    $display("master test done");
    testQueue();
    $display("queue test done");
    testBreak();
    $display("break test done");
    testStop();
    $display("stop test done");
    testDisable();
    $display("disable test done");
    testWait();
    $display("wait test done");
    testFault();
    $display("fault test done");
    testSlave();
    $display("slave test done");
    testReset();
    $display("second reset test done");
    results();
  end
endmodule
`default_nettype wire
